// ===== rtl/sbc_bus_if.sv
// shared-clock bus between the master end and the slave end
`timescale 1ns/1ps
`default_nettype none
interface sbc_bus_if
    import sbc_pkg::*;
(
    input wire logic clock,
    input wire logic resetn
);
    // master driven
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat_m2s;
    logic tgd_m2s;
    logic tga;
    logic sgl;
    logic blk;
    logic rmw;
    // slave driven
    logic ack;
    logic [DAT_W-1:0] dat_s2m;
    logic tgd_s2m;
    logic tgs;

    modport mst (
        input clock, resetn, ack, dat_s2m, tgd_s2m, tgs,
        output cyc, stb, we, adr, sel, dat_m2s, tgd_m2s, tga, sgl, blk, rmw
    );
    modport slv (
        input clock, resetn, cyc, stb, we, adr, sel, dat_m2s, tgd_m2s, tga,
        input sgl, blk, rmw,
        output ack, dat_s2m, tgd_s2m, tgs
    );
endinterface
`default_nettype wire

// ===== rtl/sbc_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sbc_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] CNT_FULL = PW'(DEPTH) == '0 ? {1'b1, {PW{1'b0}}}
                                                        : (PW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] count;
    logic [PW:0] next_count;
    logic push;
    logic pop;

    // handshakes and occupancy
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rp];
    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // storage array
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    // pointers and registered flags
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
            count <= next_count;
            in_ready <= next_count != CNT_FULL;
            out_valid <= next_count != '0;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/sbc_master.sv
// master end: single and block read/write cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module sbc_master
    import sbc_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // bus side
    sbc_bus_if.mst bus,
    // command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic cmd_block,
    input wire logic [LEN_W-1:0] cmd_count,
    input wire logic [ADR_W-1:0] cmd_adr,
    input wire logic [SEL_W-1:0] cmd_sel,
    input wire logic cmd_tag,
    // write data stream into the buffer
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [DAT_W-1:0] wr_data,
    input wire logic wr_tag,
    // read data out and master wait request
    input wire logic rd_hold,
    output logic rd_valid,
    output logic [DAT_W-1:0] rd_data,
    output logic rd_tag,
    output logic rd_stag,
    // end of cycle
    output logic done
);
    sbc_state_t state;
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat;
    logic tgd;
    logic tga;
    logic sgl;
    logic blk;
    logic [LEN_W-1:0] left;
    logic f_valid;
    logic f_ready;
    logic [FIFO_W-1:0] f_data;
    logic acked;
    logic last;
    logic can_go;
    logic start;
    logic advance;

    // write data buffer between user and bus
    sbc_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(DEPTH)
    ) u_wbuf (
        .clock(clock),
        .resetn(resetn),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data({wr_tag, wr_data}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // bus outputs come from flops, except rmw which is tied low
    assign bus.cyc = cyc;
    assign bus.stb = stb;
    assign bus.we = we;
    assign bus.adr = adr;
    assign bus.sel = sel;
    assign bus.dat_m2s = dat;
    assign bus.tgd_m2s = tgd;
    assign bus.tga = tga;
    assign bus.sgl = sgl;
    assign bus.blk = blk;
    assign bus.rmw = 1'b0; // read-modify-write not supported

    // phase completion and next-phase readiness
    assign acked = stb & bus.ack;
    assign last = left == LEN_LAST;
    assign can_go = we ? f_valid : ~rd_hold;
    assign start = (state == SBC_IDLE) & cmd_valid & cmd_ready
                   & (~cmd_write | f_valid);
    // go straight into the next phase or leave the gap
    assign advance = ((state == SBC_PHASE) & acked & ~last)
                     | (state == SBC_GAP);
    // pop write data exactly when it is loaded onto the bus
    assign f_ready = (start & cmd_write) | (we & can_go & advance);

    // sequencing of cyc and stb
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= SBC_IDLE;
            cyc <= 1'b0;
            stb <= 1'b0;
            cmd_ready <= 1'b0;
        end else begin
            case (state)
                SBC_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (start) begin
                        // cyc and stb rise together at edge 0
                        cyc <= 1'b1;
                        stb <= 1'b1;
                        cmd_ready <= 1'b0;
                        state <= SBC_PHASE;
                    end
                end
                SBC_PHASE: begin
                    if (acked && last) begin
                        cyc <= 1'b0;
                        stb <= 1'b0;
                        state <= SBC_IDLE;
                    end else if (acked && !can_go) begin
                        stb <= 1'b0;
                        state <= SBC_GAP;
                    end
                    // without ack the phase simply waits
                end
                SBC_GAP: begin
                    cyc <= 1'b1;
                    if (can_go) begin
                        stb <= 1'b1;
                        state <= SBC_PHASE;
                    end
                end
                default: begin
                    cyc <= 1'b0;
                    stb <= 1'b0;
                    state <= SBC_IDLE;
                end
            endcase
        end
    end

    // cycle attributes and cycle tags, fixed for the whole cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            we <= 1'b0;
            sel <= '0;
            tga <= 1'b0;
            sgl <= 1'b0;
            blk <= 1'b0;
        end else if (start) begin
            we <= cmd_write;
            sel <= cmd_sel;
            tga <= cmd_tag;
            sgl <= ~cmd_block;
            blk <= cmd_block;
        end else if (state == SBC_PHASE && acked && last) begin
            sgl <= 1'b0;
            blk <= 1'b0;
        end
    end

    // address and phase count; new address on the ack edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            adr <= '0;
            left <= '0;
        end else if (start) begin
            adr <= cmd_adr;
            left <= (cmd_block && cmd_count != LEN_LAST)
                    ? cmd_count - LEN_STEP : LEN_LAST;
        end else if (state == SBC_PHASE && acked && !last) begin
            adr <= adr + ADR_STEP;
            left <= left - LEN_STEP;
        end
    end

    // write data loaded from the buffer with each write phase
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dat <= '0;
            tgd <= 1'b0;
        end else if (f_ready) begin
            dat <= f_data[DAT_W-1:0];
            tgd <= f_data[DAT_W];
        end
    end

    // read capture on the acknowledged edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_valid <= 1'b0;
            rd_data <= '0;
            rd_tag <= 1'b0;
            rd_stag <= 1'b0;
        end else begin
            rd_valid <= acked & ~we;
            if (acked && !we) begin
                rd_data <= bus.dat_s2m;
                rd_tag <= bus.tgd_s2m;
                rd_stag <= bus.tgs;
            end
        end
    end

    // one pulse as the cycle ends
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            done <= 1'b0;
        end else begin
            done <= (state == SBC_PHASE) & acked & last;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/sbc_pkg.sv
// shared constants and types for the single/block cycle bus ends
package sbc_pkg;
    // bus widths
    localparam int ADR_W = 32;
    localparam int DAT_W = 32;
    localparam int SEL_W = DAT_W / 8;
    localparam int LEN_W = 8;
    // write data buffer shape
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = DAT_W + 1;
    // slave memory size in words
    localparam int MEM_WORDS = 64;
    // word address step between block phases
    localparam logic [ADR_W-1:0] ADR_STEP = 32'h0000_0001;
    // phase counter value of the final phase
    localparam logic [LEN_W-1:0] LEN_LAST = 8'h00;
    localparam logic [LEN_W-1:0] LEN_STEP = 8'h01;
    // byte lane width
    localparam int LANE_W = 8;

    // master sequencing states
    typedef enum logic [1:0] {
        SBC_IDLE = 2'b00,
        SBC_PHASE = 2'b01,
        SBC_GAP = 2'b10
    } sbc_state_t;
endpackage

// ===== rtl/sbc_slave.sv
// slave end: word memory with combinational acknowledge and wait states
`timescale 1ns/1ps
`default_nettype none
module sbc_slave
    import sbc_pkg::*;
#(
    parameter int WORDS = MEM_WORDS
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // bus side
    sbc_bus_if.slv bus,
    // user side: wait state request
    input wire logic stall,
    // user side: record of each accepted phase
    output logic evt_valid,
    output logic evt_write,
    output logic evt_block,
    output logic [ADR_W-1:0] evt_adr
);
    localparam int IW = $clog2(WORDS);

    logic [DAT_W-1:0] mem [WORDS];
    logic tag_mem [WORDS];
    logic [IW-1:0] idx;
    logic take;

    // acknowledge follows strobe with no clock in between
    assign take = bus.cyc & bus.stb & ~stall;
    assign bus.ack = take;
    // drops as soon as the strobe drops
    assign idx = bus.adr[IW-1:0];
    // read data and tag stand beside the acknowledge
    assign bus.dat_s2m = mem[idx];
    assign bus.tgd_s2m = tag_mem[idx];
    // slave tag: address falls inside the memory
    assign bus.tgs = bus.adr[ADR_W-1:IW] == '0;

    // write capture on the acknowledged edge, per byte lane
    always_ff @(posedge clock) begin
        if (take && bus.we) begin
            for (int i = 0; i < SEL_W; i++) begin
                if (bus.sel[i]) begin
                    mem[idx][i*LANE_W +: LANE_W] <=
                        bus.dat_m2s[i*LANE_W +: LANE_W];
                end
            end
            tag_mem[idx] <= bus.tgd_m2s;
        end
    end

    // one pulse per completed phase for the user
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            evt_valid <= 1'b0;
            evt_write <= 1'b0;
            evt_block <= 1'b0;
            evt_adr <= '0;
        end else begin
            evt_valid <= take;
            if (take) begin
                evt_write <= bus.we;
                evt_block <= bus.blk;
                evt_adr <= bus.adr;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/sbc_bench.sv
// master and slave ends back to back against a queue model
`timescale 1ns/1ps
`default_nettype none
module sbc_bench
    import sbc_pkg::*;
;
    // user side signals
    logic clock, resetn, stall, rd_hold, done, rd_valid, rd_tag, rd_stag;
    logic cmd_valid, cmd_ready, cmd_write, cmd_block, cmd_tag;
    logic [LEN_W-1:0] cmd_count;
    logic [ADR_W-1:0] cmd_adr, evt_adr;
    logic [SEL_W-1:0] cmd_sel;
    logic wr_valid, wr_ready, wr_tag, evt_valid, evt_write, evt_block;
    logic [DAT_W-1:0] wr_data, rd_data;
    // word model and pending write words
    logic [DAT_W:0] mem [int];
    logic [DAT_W:0] q [$];
    int errors, n_compared, n, a;
    bit waits;

    sbc_bus_if sbc_bus_if_inst (.clock(clock), .resetn(resetn));
    // bus level views for counting phases
    wire logic bus_cyc = sbc_bus_if_inst.cyc;
    wire logic acked = bus_cyc & sbc_bus_if_inst.stb & sbc_bus_if_inst.ack;
    sbc_master sbc_master_inst (.clock(clock), .resetn(resetn),
        .bus(sbc_bus_if_inst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_write(cmd_write), .cmd_block(cmd_block), .cmd_count(cmd_count),
        .cmd_adr(cmd_adr), .cmd_sel(cmd_sel), .cmd_tag(cmd_tag),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .wr_tag(wr_tag), .rd_hold(rd_hold), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_tag(rd_tag), .rd_stag(rd_stag),
        .done(done));
    sbc_slave sbc_slave_inst (.clock(clock), .resetn(resetn),
        .bus(sbc_bus_if_inst), .stall(stall), .evt_valid(evt_valid),
        .evt_write(evt_write), .evt_block(evt_block), .evt_adr(evt_adr));
    sbc_chk sbc_chk_inst (.clock(clock), .resetn(resetn), .cyc(bus_cyc),
        .stb(sbc_bus_if_inst.stb), .we(sbc_bus_if_inst.we),
        .ack(sbc_bus_if_inst.ack), .sgl(sbc_bus_if_inst.sgl),
        .blk(sbc_bus_if_inst.blk), .adr(sbc_bus_if_inst.adr),
        .sel(sbc_bus_if_inst.sel));

    // free running clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic test_done();
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(string name, logic [DAT_W:0] seen,
        logic [DAT_W:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // release reset, then both ready flags must rise
    task automatic restart();
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        check("ready", 33'({cmd_ready, wr_ready}), 33'h3);
    endtask

    // offer fresh words for n cycles, count those taken
    task automatic feed(int n, int exp);
        int got;
        got = 0;
        repeat (n) begin
            @(negedge clock);
            wr_valid = 1'b1;
            wr_data = $urandom;
            wr_tag = 1'($urandom);
            #1;
            if (wr_ready === 1'b1) begin
                q.push_back({wr_tag, wr_data});
                got++;
            end
        end
        @(negedge clock);
        wr_valid = 1'b0;
        check("taken", 33'(got), 33'(exp));
    endtask

    // one command, watched until its end pulse
    task automatic run(bit w, bit b, int n, int a, logic [SEL_W-1:0] s);
        int ph, rd, ev, cy, m, k;
        bit fin;
        logic [DAT_W:0] d;
        {ph, rd, ev, cy, fin} = '0;
        m = (b && n > 1) ? n : 1;
        {cmd_write, cmd_block, cmd_sel} = {w, b, s};
        cmd_count = LEN_W'(n);
        cmd_adr = ADR_W'(a);
        cmd_tag = 1'($urandom);
        cmd_valid = 1'b1;
        for (k = 0; k < 50 && cmd_ready !== 1'b1; k++) begin
            @(negedge clock);
        end
        if (cmd_ready !== 1'b1) begin
            errors++;
            test_done();
        end
        @(negedge clock);
        cmd_valid = 1'b0;
        for (k = 0; k < 400 && !fin; k++) begin
            stall = waits && $urandom % 3 == 0;
            rd_hold = waits && $urandom % 4 == 0;
            // late write data forces master gaps
            wr_valid = w && q.size() < m && $urandom % 2 == 0;
            wr_data = $urandom;
            wr_tag = 1'($urandom);
            #1;
            if (wr_valid && wr_ready === 1'b1) begin
                q.push_back({wr_tag, wr_data});
            end
            cy += bus_cyc;
            ph += acked;
            if (rd_valid === 1'b1) begin
                check("rd_data", {rd_tag, rd_data}, mem[a + rd]);
                check("rd_stag", 33'(rd_stag), 33'h1);
                rd++;
            end
            if (evt_valid === 1'b1) begin
                check("evt", {evt_write, evt_block, evt_adr[30:0]},
                    {w, b, 31'(a + ev)});
                ev++;
            end
            fin = done === 1'b1;
            @(negedge clock);
        end
        wr_valid = 1'b0;
        if (!fin) begin
            errors++;
            test_done();
        end
        check("phases", 33'(ph), 33'(m));
        check("reads", 33'(rd), w ? 33'h0 : 33'(m));
        if (!waits) check("cycles", 33'(cy), 33'(m));
        for (k = 0; k < m && w; k++) begin
            d = q.pop_front();
            for (int j = 0; j < SEL_W; j++) begin
                if (s[j]) begin
                    mem[a + k][j*LANE_W +: LANE_W] = d[j*LANE_W +: LANE_W];
                end
            end
            mem[a + k][DAT_W] = d[DAT_W];
        end
    endtask

    // main sequence
    initial begin
        {resetn, stall, rd_hold, cmd_valid, cmd_write, cmd_block} = '0;
        {cmd_tag, cmd_count, cmd_adr, cmd_sel, wr_valid, wr_tag} = '0;
        wr_data = '0;
        void'($urandom(32'h16ec6d97));
        restart();
        // single write, lane merge, single read
        feed(1, 1);
        run(1, 0, 1, 3, 4'hf);
        feed(1, 1);
        run(1, 0, 1, 3, 4'h5);
        run(0, 0, 1, 3, 4'hf);
        // fill the buffer, drain it with slave waits, read it back with both sides waiting
        feed(20, FIFO_DEPTH);
        waits = 1'b1;
        run(1, 1, 16, 8, 4'hf);
        run(0, 1, 16, 8, 4'hf);
        // write data arriving late, master gaps with cyc held
        feed(1, 1);
        run(1, 1, 3, 56, 4'hf);
        run(0, 1, 3, 56, 4'hf);
        // zero count block, an unthrottled block read, then blocks with waits on or off at random
        waits = 1'b0;
        feed(1, 1);
        run(1, 1, 0, 40, 4'hf);
        run(0, 1, 4, 8, 4'hf);
        repeat (4) begin
            n = 1 + $urandom % 7;
            a = $urandom % 56;
            waits = 1'($urandom);
            feed(n, n);
            run(1, 1, n, a, 4'hf);
            run(0, 1, n, a, 4'hf);
        end
        // reset in the middle of a block read
        {cmd_write, cmd_block, cmd_count, cmd_adr} = {2'b01, 8'h10, 32'h8};
        cmd_valid = 1'b1;
        repeat (4) @(negedge clock);
        resetn = 1'b0;
        cmd_valid = 1'b0;
        #1;
        check("reset_idle", 33'({bus_cyc, cmd_ready}), 33'h0);
        restart();
        feed(1, 1);
        run(1, 0, 1, 50, 4'hf);
        run(0, 0, 1, 50, 4'hf);
        test_done();
    end
endmodule
`default_nettype wire

// ===== verification/sbc_chk.sv
// bus protocol assertions for the master and slave ends
`timescale 1ns/1ps
`default_nettype none
module sbc_chk
    import sbc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // bus signals
    input wire logic cyc,
    input wire logic stb,
    input wire logic we,
    input wire logic ack,
    input wire logic sgl,
    input wire logic blk,
    input wire logic [ADR_W-1:0] adr,
    input wire logic [SEL_W-1:0] sel
);
    // one clock domain for every check
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    chk_stb_in_cyc: assert property (stb |-> cyc)
        else $error("strobe outside cycle");
    chk_ack_follows: assert property (ack |-> stb)
        else $error("ack without strobe");
    chk_phase_hold: assert property (stb && !ack |=>
        stb && $stable(adr) && $stable(we) && $stable(sel))
        else $error("phase changed before ack");
    chk_single_end: assert property (stb && ack && sgl |=> !stb && !cyc)
        else $error("single cycle did not end");
    chk_start_tag: assert property ($rose(cyc) |-> stb && sgl != blk)
        else $error("bad cycle start");
    chk_block_step: assert property (blk && ack ##1 stb |->
        adr == $past(adr) + ADR_STEP)
        else $error("block address did not step");
    chk_end_acked: assert property ($fell(cyc) |-> $past(ack))
        else $error("cycle ended without ack");
    chk_reset_idle: assert property ($rose(resetn) |->
        !cyc && !stb ##1 !cyc)
        else $error("cycle right after reset");
    // main scenarios reached
    cover property (stb && ack && sgl && we);
    cover property (stb && ack && blk && !we);
    cover property (cyc && !stb);
    cover property (stb && !ack);
endmodule
`default_nettype wire
